// ===== host_cpu_model.sv
/* Host processor on the 8-bit port: write strobe clock and read pins.
   Assumes the bench calls one task at a time. */
`timescale 1ns/1ns
module host_cpu_model (
    output logic       o_wr_clk,
    output logic [2:0] o_addr,
    output logic       o_ce_n,
    output logic       o_rd_n,
    output logic [7:0] o_data
);
    initial {o_wr_clk, o_addr, o_ce_n, o_rd_n, o_data} = {1'b0, 3'h0, 2'b11, 8'h00};
    // Strobe stands still between writes; rising edges at least 70 ns apart, high for 15 ns
    task write(input logic [2:0] a, input logic [7:0] d, input logic cs_n);
        o_ce_n = cs_n;
        o_rd_n = 1'b1;
        o_addr = a;
        o_data = d;
        #10 o_wr_clk = 1'b1;
        #15 o_wr_clk = 1'b0;
        #5 o_ce_n = 1'b1;
        o_addr = ~a;
        o_data = ~d; // Released bus shows no stale value
        #40;
    endtask
    // Deselected strobe period, used only around reset
    task tick();
        #15 o_wr_clk = 1'b1;
        #15 o_wr_clk = 1'b0;
    endtask
    task read_on(input logic [2:0] a);
        o_ce_n = 1'b0;
        o_rd_n = 1'b0;
        o_addr = a;
        o_data = ~o_data;
    endtask
    task read_off();
        o_rd_n = 1'b1;
        o_ce_n = 1'b1;
    endtask
endmodule

// ===== host_port_memory_access.sv
/*
 * Memory-access part of the 8-bit parallel host port: staging word,
 * control words, memory word buffer, coefficient and constellation RAMs,
 * and byte-wise readback.
 * Assumes the host write strobe is a clock that only runs during writes,
 * at most a quarter of the core clock rate, and that the readback-only
 * FIFO word is supplied by core logic for the address on o_fifo_read_addr.
 */
`timescale 1ns/1ns

module host_port_memory_access
    import host_port_pkg::*;
(
    input  wire logic              i_ref_clk,        // Core clock
    input  wire logic              i_reset,          // Core reset
    input  wire logic              i_wr_clk,         // Host write strobe
    input  wire logic [2:0]        i_addr,           // Port address
    input  wire logic              i_ce_n,           // Chip select
    input  wire logic              i_rd_n,           // Read strobe
    input  wire logic [BYTE_W-1:0] i_host_data,      // Host data bus in
    input  wire logic [FIFO_W-1:0] i_fifo_word,      // FIFO word to read
    output logic      [BYTE_W-1:0] o_host_data,      // Host data bus out
    output logic                   o_host_data_oe,   // Bus driver enable
    output mem_ctrl_s              o_mem_ctrl,       // Memory control word
    output ctrl_write_s            o_ctrl_write,     // Control word update
    output logic      [MAP_AW-1:0] o_fifo_read_addr  // FIFO readback address
);

    // ------------------------------------
    // Write-strobe domain
    // ------------------------------------
    // Each accepted write lands in one of two slots and flips a toggle.
    // Two slots let the core read a slot while the host fills the other;
    // a slot is only reused two writes later, well after the core took it.
    typedef struct packed {
        logic        tog;     // Flips once per accepted write
        host_event_s slot0;   // Capture while toggle is 0
        host_event_s slot1;   // Capture while toggle is 1
    } wr_state_s;

    wr_state_s wr_state;
    wr_state_s next_wr_state;
    logic      wr_reset;      // Core reset seen on the write strobe

    // Reset reaches this domain only on write strobe edges
    two_flop_sync #(
        .WIDTH     (1),
        .RESET_VAL (1'b0)
    ) u_wr_reset_sync (
        .i_clk   (i_wr_clk),
        .i_reset (1'b0),
        .i_async (i_reset),
        .o_sync  (wr_reset)
    );

    // Capture writes made with chip select and without read strobe
    always_comb begin
        next_wr_state = wr_state;
        if (!i_ce_n && i_rd_n) begin // RULE17
            if (wr_state.tog) begin
                next_wr_state.slot1 = '{addr: i_addr, data: i_host_data};
            end else begin
                next_wr_state.slot0 = '{addr: i_addr, data: i_host_data};
            end
            next_wr_state.tog = ~wr_state.tog;
        end
        if (wr_reset) begin
            next_wr_state = '0;
        end
    end

    // Register the write-strobe state
    always_ff @(posedge i_wr_clk) begin
        wr_state <= next_wr_state;
    end

    // ------------------------------------
    // Crossings into the core domain
    // ------------------------------------
    logic       tog_sync;     // Toggle after two flops
    read_pins_s pins_sync;    // Read selectors after two flops

    two_flop_sync #(
        .WIDTH     (1),
        .RESET_VAL (1'b0)
    ) u_tog_sync (
        .i_clk   (i_ref_clk),
        .i_reset (i_reset),
        .i_async (wr_state.tog),
        .o_sync  (tog_sync)
    );

    // Read pins idle high, so the bus stays undriven out of reset
    two_flop_sync #(
        .WIDTH     ($bits(read_pins_s)),
        .RESET_VAL ({3'h0, 1'b1, 1'b1})
    ) u_pins_sync (
        .i_clk   (i_ref_clk),
        .i_reset (i_reset),
        .i_async ({i_addr, i_ce_n, i_rd_n}),
        .o_sync  (pins_sync)
    );

    // ------------------------------------
    // Core state
    // ------------------------------------
    typedef struct packed {
        logic                seen;       // Toggle value consumed so far
        logic [STAGE_W-1:0]  staging_word;
        mem_ctrl_s           mem_ctrl;   // Memory control word
        logic [1:0]          word_sel;   // Word select counter
        logic [BUF_W-1:0]    memory_word_buffer;
        logic [MAP_AW-1:0]   auto_addr;  // Auto-increment address
        logic [MAP_AW-1:0]   readback_memory_address;
        logic [3:0]          readback_byte_counter;
        logic [4:0]          readback_word_index;
        logic [BYTE_W-1:0]   dout;       // Registered read byte
        logic                doe;        // Registered driver enable
        ctrl_write_s         ctrl_write; // Update pulse to datapath
    } core_s;

    core_s state;
    core_s next_state;

    // Memories, too large to sit in the state record
    logic [STAGE_W-1:0] ctrl_words [CW_COUNT];
    logic [BUF_W-1:0]   coef_i     [2**COEF_AW];
    logic [BUF_W-1:0]   coef_q     [2**COEF_AW];
    logic [BYTE_W-1:0]  map_ram    [2**MAP_AW];

    // Write requests toward the memories, built with the next state
    logic               cw_we;       // Control word write
    logic [4:0]         cw_idx;      // Control word index
    logic               coef_i_we;   // I coefficient write
    logic               coef_q_we;   // Q coefficient write
    logic               map_we;      // Constellation map write
    logic [MAP_AW-1:0]  ram_addr;    // Target memory address

    // Working values of the core process
    host_event_s        ev;          // Event being consumed
    logic               ev_valid;    // An event is pending
    logic               strobe;      // Buffer load strobe
    logic [BUF_W-1:0]   rb_word;     // Word at the readback address
    logic [3:0]         rb_bytes;    // Bytes in that word
    logic [BYTE_W-1:0]  rb_byte;     // Memory byte for reads at 4..7
    logic [STAGE_W-1:0] cw_word;     // Control word being read

    // ------------------------------------
    // Readback selection
    // ------------------------------------
    // Pick the memory word and its byte count from the select field
    always_comb begin
        rb_word  = '0;
        rb_bytes = BYTES_COEF;
        unique case (state.mem_ctrl.sel) // RULE16
            SEL_I, SEL_IQ: begin
                rb_word = coef_i[state.readback_memory_address[COEF_AW-1:0]];
            end
            SEL_Q: begin
                rb_word = coef_q[state.readback_memory_address[COEF_AW-1:0]];
            end
            SEL_MAP: begin
                rb_word  = {{(BUF_W-BYTE_W){1'b0}},
                            map_ram[state.readback_memory_address]};
                rb_bytes = BYTES_MAP; // RULE7
            end
            SEL_FIFO: begin
                rb_word  = {{(BUF_W-FIFO_W){1'b0}}, i_fifo_word};
                rb_bytes = BYTES_FIFO; // RULE7
            end
            default: begin
                rb_bytes = '0; // No memory: reads return zero
            end
        endcase
        // Bytes past the end of the word read as zero
        if (state.readback_byte_counter < rb_bytes) begin
            rb_byte = rb_word[state.readback_byte_counter * BYTE_W +: BYTE_W];
        end else begin
            rb_byte = '0;
        end
        cw_word = ctrl_words[state.readback_word_index];
    end

    // ------------------------------------
    // Core next state
    // ------------------------------------
    // One host write is consumed per toggle change. The read byte is
    // rebuilt every cycle from the live selectors, so it follows the
    // address pins with the synchroniser delay plus one register stage.
    always_comb begin
        next_state = state;
        next_state.ctrl_write.valid = 1'b0;
        cw_we     = 1'b0;
        cw_idx    = '0;
        coef_i_we = 1'b0;
        coef_q_we = 1'b0;
        map_we    = 1'b0;
        ram_addr  = state.auto_addr;
        strobe    = 1'b0;
        ev_valid  = (tog_sync != state.seen);
        ev        = state.seen ? wr_state.slot1 : wr_state.slot0;

        if (ev_valid) begin
            next_state.seen = ~state.seen;
            unique case (ev.addr)
                PADDR_LOAD: begin
                    if (ev.data[4:0] == CW_LOAD_STROBE) begin
                        strobe = 1'b1; // RULE2
                    end else begin
                        cw_we  = 1'b1; // RULE12
                        cw_idx = ev.data[4:0];
                        next_state.ctrl_write = '{valid: 1'b1,
                                                  index: ev.data[4:0],
                                                  data:  state.staging_word};
                    end
                end
                PADDR_RB_INDEX: begin
                    next_state.readback_word_index = ev.data[4:0]; // RULE13
                end
                PADDR_RB_ADDR: begin
                    next_state.readback_memory_address = ev.data; // RULE8
                    next_state.readback_byte_counter   = COUNT_RESET;
                end
                PADDR_RB_STEP: begin
                    next_state.readback_byte_counter =
                        state.readback_byte_counter + 4'h1; // RULE9
                end
                default: begin
                    // Addresses 0..3 fill one staging byte each
                    next_state.staging_word[ev.addr[1:0] * BYTE_W +: BYTE_W] =
                        ev.data; // RULE11
                end
            endcase
        end

        // Memory control word also loads the word select counter
        if (cw_we && (cw_idx == CW_MEMCTRL)) begin
            next_state.mem_ctrl = mem_ctrl_s'(state.staging_word[BYTE_W-1:0]);
            next_state.word_sel = state.staging_word[1:0];
            if (state.staging_word[6]) begin
                next_state.auto_addr = ADDR_RESET; // RULE1
            end
        end

        // Buffer load strobe
        if (strobe) begin
            // Manual mode takes the address from the staging top byte
            if (!state.mem_ctrl.auto_inc) begin
                ram_addr = state.staging_word[STAGE_W-1 -: BYTE_W]; // RULE5
            end
            if (state.mem_ctrl.sel == SEL_MAP) begin
                next_state.memory_word_buffer[BUF_W-1 -: BYTE_W] =
                    state.staging_word[SLICE_W-1 -: BYTE_W]; // RULE6
                if (state.word_sel == WS_FIRST) begin
                    map_we = !state.mem_ctrl.read_mode; // RULE6
                end
                next_state.word_sel = WS_FIRST;
            end else begin
                next_state.memory_word_buffer[state.word_sel * SLICE_W +: SLICE_W]
                    = state.staging_word[SLICE_W-1:0]; // RULE3
                if (state.word_sel == WS_LAST) begin
                    // Final slice: commit the whole word
                    coef_i_we = !state.mem_ctrl.read_mode &&
                                ((state.mem_ctrl.sel == SEL_I) ||
                                 (state.mem_ctrl.sel == SEL_IQ)); // RULE4
                    coef_q_we = !state.mem_ctrl.read_mode &&
                                ((state.mem_ctrl.sel == SEL_Q) ||
                                 (state.mem_ctrl.sel == SEL_IQ)); // RULE4
                    next_state.word_sel = WS_FIRST; // RULE4
                end else begin
                    next_state.word_sel = state.word_sel + 2'h1; // RULE3
                end
            end
            // Sequential fill in auto mode
            if (state.mem_ctrl.auto_inc && (coef_i_we || coef_q_we || map_we)) begin
                next_state.auto_addr = state.auto_addr + 8'h01; // RULE18
            end
        end

        // Read byte: control word bytes at 0..3, memory bytes at 4..7
        next_state.doe = !pins_sync.ce_n && !pins_sync.rd_n; // RULE14
        if (pins_sync.addr[2]) begin
            next_state.dout = rb_byte; // RULE10
        end else begin
            next_state.dout = cw_word[pins_sync.addr[1:0] * BYTE_W +: BYTE_W]; // RULE14
        end

        if (i_reset) begin
            next_state      = '0;
            next_state.seen = tog_sync;
        end
    end

    // ------------------------------------
    // Registers
    // ------------------------------------
    // Core state record
    always_ff @(posedge i_ref_clk) begin
        state <= next_state;
    end

    // Control words, cleared by reset so readback is defined
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            for (int k = 0; k < CW_COUNT; k++) begin
                ctrl_words[k] <= CW_RESET;
            end
        end else if (cw_we) begin
            ctrl_words[cw_idx] <= state.staging_word; // RULE12
        end
    end

    // Memories hold no reset; software loads them before use.
    // The committed word includes the slice landing this cycle.
    always_ff @(posedge i_ref_clk) begin
        if (coef_i_we) begin
            coef_i[ram_addr[COEF_AW-1:0]] <= next_state.memory_word_buffer; // RULE4
        end
        if (coef_q_we) begin
            coef_q[ram_addr[COEF_AW-1:0]] <= next_state.memory_word_buffer; // RULE4
        end
        if (map_we) begin
            map_ram[ram_addr] <= next_state.memory_word_buffer[BUF_W-1 -: BYTE_W];
        end
    end

    // ------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------
    assign o_host_data      = state.dout;
    assign o_host_data_oe   = state.doe;
    assign o_mem_ctrl       = state.mem_ctrl;
    assign o_ctrl_write     = state.ctrl_write;
    assign o_fifo_read_addr = state.readback_memory_address;

endmodule

// ===== host_port_memory_access_chk.sv
/* Port-level assertions for the host port memory block.
   Assumes it is bound to the block and sees only its ports. */
`timescale 1ns/1ns
module host_port_memory_access_chk
    import host_port_pkg::*;
(
    input logic        i_ref_clk,
    input logic        i_reset,
    input logic        i_ce_n,
    input logic        i_rd_n,
    input logic        o_host_data_oe,
    input mem_ctrl_s   o_mem_ctrl,
    input ctrl_write_s o_ctrl_write
);
    // ----------------------------------------
    // One clock domain, one reset
    // ----------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    a_reset_clears_out: assert property ($past(i_reset) |-> !o_host_data_oe &&
        o_mem_ctrl == 8'h00 && !o_ctrl_write.valid) else $error("reset outputs");
    a_oe_on_read: assert property ((!i_ce_n && !i_rd_n)[*5] |-> o_host_data_oe)
        else $error("oe missing");
    a_oe_off_idle: assert property ((i_ce_n || i_rd_n)[*5] |-> !o_host_data_oe)
        else $error("oe while idle");
    a_oe_rise_cause: assert property ($rose(o_host_data_oe) |->
        $past(!i_ce_n && !i_rd_n, 3)) else $error("oe rose alone");
    a_oe_fall_cause: assert property ($fell(o_host_data_oe) |->
        $past(i_ce_n || i_rd_n, 3)) else $error("oe fell early");
    a_valid_one_pulse: assert property (o_ctrl_write.valid |=> !o_ctrl_write.valid[*4])
        else $error("pulse too long");
    a_strobe_not_stored: assert property (o_ctrl_write.valid |->
        o_ctrl_write.index != 5'h0f) else $error("strobe stored");
    a_memctrl_cause: assert property ($changed(o_mem_ctrl) |->
        o_ctrl_write.valid && o_ctrl_write.index == 5'h00) else $error("ctrl changed");
    a_memctrl_value: assert property (o_ctrl_write.valid &&
        o_ctrl_write.index == 5'h00 |=> o_mem_ctrl == $past(o_ctrl_write.data[7:0]))
        else $error("ctrl value");
endmodule

bind host_port_memory_access host_port_memory_access_chk i_host_port_memory_access_chk (
    .i_ref_clk, .i_reset, .i_ce_n, .i_rd_n, .o_host_data_oe, .o_mem_ctrl, .o_ctrl_write);

// ===== host_port_memory_access_test.sv
/* Self-checking bench with a behavioural model of the host port.
   Assumes the host model drives the port pins. */
`timescale 1ns/1ns
module host_port_memory_access_test;
    import host_port_pkg::*;
    logic        i_ref_clk, i_reset, wr_clk, ce_n, rd_n, oe;
    logic [2:0]  addr;
    logic [7:0]  hdata, o_host_data, fra, raddr;
    logic [31:0] fifo, stg;
    logic [31:0] cw [32];
    logic [71:0] mbuf;
    logic [71:0] mi [64], mq [64];
    logic [7:0]  mm [256];
    mem_ctrl_s   mctl;
    ctrl_write_s cwo, last_cw;
    int          ws, auto_a, ridx, bc, seed, bad_count, checks, vcnt;
    host_cpu_model i_host_cpu_model (.o_wr_clk(wr_clk), .o_addr(addr), .o_ce_n(ce_n),
        .o_rd_n(rd_n), .o_data(hdata));
    host_port_memory_access i_host_port_memory_access (.i_ref_clk,
        .i_reset, .i_wr_clk(wr_clk), .i_addr(addr), .i_ce_n(ce_n), .i_rd_n(rd_n),
        .i_host_data(hdata), .i_fifo_word(fifo), .o_host_data,
        .o_host_data_oe(oe), .o_mem_ctrl(mctl), .o_ctrl_write(cwo), .o_fifo_read_addr(fra));
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    // Capture each control word update pulse
    always @(posedge i_ref_clk) if (cwo.valid === 1'b1) begin
        last_cw <= cwo;
        vcnt <= vcnt + 1;
    end
    task chk(input logic [71:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task print_verdict();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Host write plus model update
    task wr(input logic [2:0] a, input logic [7:0] d);
        logic [2:0] sel;
        logic [7:0] ad;
        @(posedge i_ref_clk);
        #1 i_host_cpu_model.write(a, d, 1'b0);
        sel = cw[0][4:2];
        ad = cw[0][6] ? 8'(auto_a) : stg[31:24];
        case (a)
            3'h4: if (d[4:0] == 5'h0f) begin
                if (sel == 3'h4) begin
                    mbuf[71:64] = stg[23:16];
                    if (!cw[0][5]) mm[ad] = mbuf[71:64];
                    if (!cw[0][5]) auto_a++;
                end else if (ws == 2) begin
                    mbuf[71:48] = stg[23:0];
                    if (!cw[0][5] && sel[0] && !sel[2]) mi[ad[5:0]] = mbuf;
                    if (!cw[0][5] && sel[1] && !sel[2]) mq[ad[5:0]] = mbuf;
                    if (!cw[0][5] && sel != 3'h0 && !sel[2]) auto_a++;
                    ws = 0;
                end else begin
                    mbuf[ws*24+:24] = stg[23:0];
                    ws++;
                end
            end else begin
                cw[d[4:0]] = stg;
                if (d[4:0] == 5'h00) ws = stg[1:0];
                if (d[4:0] == 5'h00 && stg[6]) auto_a = 0;
            end
            3'h5: ridx = d[4:0];
            3'h6: begin
                raddr = d;
                bc = 0;
            end
            3'h7: bc++;
            default: stg[a*8+:8] = d;
        endcase
    endtask
    function logic [7:0] exp_byte(input logic [2:0] pa);
        logic [2:0] sel;
        sel = cw[0][4:2];
        if (pa < 3'h4) return cw[ridx][pa*8+:8];
        if (sel == 3'h1 || sel == 3'h3) return bc < 9 ? mi[raddr[5:0]][bc*8+:8] : 8'h00;
        if (sel == 3'h2) return bc < 9 ? mq[raddr[5:0]][bc*8+:8] : 8'h00;
        if (sel == 3'h4) return bc == 0 ? mm[raddr] : 8'h00;
        if (sel == 3'h5) return bc < 4 ? fifo[bc*8+:8] : 8'h00;
        return 8'h00;
    endfunction
    task rd(input logic [2:0] pa);
        @(posedge i_ref_clk);
        #1 i_host_cpu_model.read_on(pa);
        repeat (5) @(posedge i_ref_clk);
        chk(oe, 1'b1);
        chk(o_host_data, exp_byte(pa));
        #1 i_host_cpu_model.read_off();
        repeat (5) @(posedge i_ref_clk);
    endtask
    task setcw0(input logic [7:0] v);
        wr(3'h0, v);
        wr(3'h4, 8'h00);
    endtask
    task cwtest(input logic [4:0] idx, input logic [31:0] v);
        int c0;
        for (int k = 0; k < 4; k++) wr(3'(k), v[k*8+:8]);
        c0 = vcnt;
        wr(3'h4, {3'h0, idx});
        for (int n = 0; n < 20 && vcnt == c0; n++) @(posedge i_ref_clk);
        if (vcnt == c0) begin
            bad_count++;
            print_verdict();
        end
        chk(last_cw, {1'b1, idx, v});
        wr(3'h5, {3'h0, idx});
        for (int k = 0; k < 4; k++) rd(3'(k));
    endtask
    task load(input logic [71:0] w, input logic [7:0] a, input logic use_a);
        for (int k = 0; k < 3; k++) begin
            for (int b = 0; b < 3; b++) wr(3'(b), w[k*24+b*8+:8]);
            if (k == 2 && use_a) wr(3'h3, a);
            wr(3'h4, 8'h0f);
        end
    endtask
    task rb(input logic [7:0] c, input logic [7:0] a, input int n);
        setcw0(c);
        wr(3'h6, a);
        chk(fra, a);
        for (int i = 0; i <= n; i++) begin
            rd(3'(4 + i % 4));
            wr(3'h7, 8'h00);
        end
    endtask
    function logic [71:0] rnd72();
        return {8'($random(seed)), 32'($random(seed)), 32'($random(seed))};
    endfunction
    initial begin
        {seed, bad_count, checks, vcnt, ws, auto_a, ridx, bc} = {32'd10, 224'd0};
        {i_reset, fifo, stg, raddr} = {1'b1, 72'h0};
        foreach (cw[k]) cw[k] = 32'h0;
        repeat (3) i_host_cpu_model.tick();
        repeat (3) @(posedge i_ref_clk);
        #1 i_reset = 1'b0;
        repeat (3) i_host_cpu_model.tick();
        chk({mctl, fra}, 16'h0000);
        for (int k = 0; k < 3; k++) cwtest(5'(k * 14 + 3), $random(seed));
        i_host_cpu_model.write(3'h4, 8'h05, 1'b1);
        repeat (10) @(posedge i_ref_clk);
        chk(last_cw.index, 5'h1f);
        $display("control word test done");
        setcw0(8'h04);
        load(rnd72(), 8'h12, 1'b1);
        setcw0(8'h0c);
        load(rnd72(), 8'h05, 1'b1);
        setcw0(8'h44);
        load(rnd72(), 8'h00, 1'b0);
        load(rnd72(), 8'h00, 1'b0);
        rb(8'h24, 8'h12, 9);
        rb(8'h24, 8'h00, 9);
        rb(8'h24, 8'h01, 9);
        rb(8'h28, 8'h05, 9);
        rb(8'h24, 8'h05, 9);
        $display("coefficient test done");
        setcw0(8'h10);
        wr(3'h2, 8'($random(seed)));
        wr(3'h3, 8'h9a);
        wr(3'h4, 8'h0f);
        rb(8'h30, 8'h9a, 1);
        fifo = $random(seed);
        rb(8'h34, 8'h77, 4);
        rb(8'h20, 8'h12, 0);
        $display("map and fifo test done");
        print_verdict();
    end
endmodule

// ===== host_port_pkg.sv
/*
 * Constants, field layouts and carrier types for the memory-access part of
 * the 8-bit parallel host port.
 * Assumes it is compiled before every module that imports it.
 */
// Summary of operation
// (RULE1) Auto mode: control word 0 write clears address
// (RULE2) Load 0x0F at address 4 fires buffer strobe
// (RULE3) Strobe advances select; picks buffer slice
// (RULE4) Select at 2: write 72 bits, clear
// (RULE5) Final strobe takes address from staging top
// (RULE6) Map RAM: select 0 writes bits 71:64
// (RULE7) Readback bytes: coefficient 9, map 1, FIFO 4
// (RULE8) Address 6 write: readback address, counter cleared
// (RULE9) Address 7 write steps readback byte counter
// (RULE10) Reads at 4 to 7 return memory byte
// (RULE11) Addresses 0 to 3 fill staging bytes
// (RULE12) Address 4 copies staging into indexed control word
// (RULE13) Address 5 latches readback control word index
// (RULE14) Read pins select bytes; read strobe drives bus
// (RULE15) Host presets word select to 00 first
// (RULE16) Memory select decode: none, I, Q, both, map, FIFO
// (RULE17) Accesses without chip select are ignored
// (RULE18) Auto mode: address advances after each word
package host_port_pkg;

    // ------------------------------------
    // Widths and depths
    // ------------------------------------
    localparam int BYTE_W    = 8;
    localparam int STAGE_W   = 32;
    localparam int SLICE_W   = 24;
    localparam int BUF_W     = 72;
    localparam int CW_COUNT  = 32;
    localparam int COEF_AW   = 6;
    localparam int MAP_AW    = 8;
    localparam int FIFO_W    = 32;

    // ------------------------------------
    // Port addresses
    // ------------------------------------
    localparam logic [2:0] PADDR_LOAD     = 3'h4;
    localparam logic [2:0] PADDR_RB_INDEX = 3'h5;
    localparam logic [2:0] PADDR_RB_ADDR  = 3'h6;
    localparam logic [2:0] PADDR_RB_STEP  = 3'h7;

    // ------------------------------------
    // Control word indices and reset values
    // ------------------------------------
    localparam logic [4:0]  CW_MEMCTRL     = 5'h00;
    localparam logic [4:0]  CW_LOAD_STROBE = 5'h0f;
    localparam logic [31:0] CW_RESET       = 32'h0000_0000;
    localparam logic [7:0]  ADDR_RESET     = 8'h00;
    localparam logic [3:0]  COUNT_RESET    = 4'h0;

    // ------------------------------------
    // Word select counter values and bytes per readback address
    // ------------------------------------
    localparam logic [1:0] WS_FIRST   = 2'h0;
    localparam logic [1:0] WS_LAST    = 2'h2;
    localparam logic [3:0] BYTES_COEF = 4'h9;
    localparam logic [3:0] BYTES_MAP  = 4'h1;
    localparam logic [3:0] BYTES_FIFO = 4'h4;

    // Memory select field codes
    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_I    = 3'h1,
        SEL_Q    = 3'h2,
        SEL_IQ   = 3'h3,
        SEL_MAP  = 3'h4,
        SEL_FIFO = 3'h5,
        SEL_RSV6 = 3'h6,
        SEL_RSV7 = 3'h7
    } mem_sel_e;

    // Memory control word, low byte of control word 0
    typedef struct packed {
        logic     spare;
        logic     auto_inc;
        logic     read_mode;
        mem_sel_e sel;
        logic [1:0] word_sel;
    } mem_ctrl_s;

    // One captured host write
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] data;
    } host_event_s;

    // Read-side pins, used as live byte selectors
    typedef struct packed {
        logic [2:0] addr;
        logic       ce_n;
        logic       rd_n;
    } read_pins_s;

    // Control word handed to the core datapath
    typedef struct packed {
        logic        valid;
        logic [4:0]  index;
        logic [31:0] data;
    } ctrl_write_s;

endpackage

// ===== two_flop_sync.sv
/*
 * Two flip-flop synchroniser for a bundle of level signals.
 * Assumes each bit is an independent level or a bus that is quiet while
 * it is being read.
 */
`timescale 1ns/1ns

module two_flop_sync #(
    parameter int         WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    // ------------------------------------
    // State
    // ------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] meta;    // First stage, read by second only
        logic [WIDTH-1:0] stable;  // Second stage, safe to use
    } sync_s;

    sync_s state;
    sync_s next_state;

    // Shift the input through both stages
    always_comb begin
        next_state.meta   = i_async;
        next_state.stable = state.meta;
        if (i_reset) begin
            next_state.meta   = RESET_VAL;
            next_state.stable = RESET_VAL;
        end
    end

    // Register the stages
    always_ff @(posedge i_clk) begin
        state <= next_state;
    end

    assign o_sync = state.stable;

endmodule
